// *** shared/sysopt_pkg.sv ***
// package for the system option control register bank
package sysopt_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] SO_OFF_OPT1 = 8'h00;
   localparam logic [7:0] SO_OFF_OPT2 = 8'h04;
   localparam logic [7:0] SO_OFF_IDH = 8'h08;
   localparam logic [7:0] SO_OFF_IDL = 8'h0c;
   localparam logic [7:0] SO_OFF_WAKE = 8'h10;
   localparam logic [7:0] SO_OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] SO_OFF_IRQ_MASK = 8'h18;
   // system_options_one field positions
   localparam int SO_OPT1_WDOG_EN_BIT = 7;
   localparam int SO_OPT1_WDOG_LONG_BIT = 6;
   localparam int SO_OPT1_SLEEP_BIT = 5;
   localparam int SO_OPT1_RSVD_BIT = 4;
   localparam int SO_OPT1_DEBUG_BIT = 1;
   localparam int SO_OPT1_RSTPIN_BIT = 0;
   // system_options_two field position
   localparam int SO_OPT2_WDOG_CLK_BIT = 7;
   // periodic_wakeup_ctrl field positions
   localparam int SO_WAKE_FLAG_BIT = 7;
   localparam int SO_WAKE_ACK_BIT = 6;
   localparam int SO_WAKE_CLK_BIT = 5;
   localparam int SO_WAKE_IE_BIT = 4;
   localparam int SO_WAKE_SEL_LSB = 0;
   // interrupt status and mask bit positions
   localparam int SO_IRQ_WAKE_BIT = 0;
   localparam int SO_IRQ_STOP_BIT = 1;
   // reset values
   localparam logic SO_RST_WDOG_EN = 1'b1;
   localparam logic SO_RST_WDOG_LONG = 1'b1;
   localparam logic SO_RST_SLEEP = 1'b0;
   localparam logic SO_RST_RSVD = 1'b1;
   localparam logic SO_RST_DEBUG = 1'b1;
   localparam logic SO_RST_RSTPIN = 1'b0;
   localparam logic SO_RST_WDOG_CLK = 1'b0;
   localparam logic [7:0] SO_RST_WAKE = 8'h00;
   // wakeup period figures: first step, base of later steps, and 32 kHz multiplier
   localparam int SO_WAKE_1K_FIRST = 8;
   localparam int SO_WAKE_1K_BASE = 32;
   localparam int SO_WAKE_EXT_MULT = 32;
   localparam int SO_WAKE_CNT_W = 16;
   // register state of the bank, all but the power-on domain reset pin bit
   typedef struct packed {
      logic [2:0] sync_1k;
      logic [2:0] sync_32k;
      logic watchdog_enable;
      logic watchdog_long_timeout;
      logic deep_sleep_permit;
      logic opt1_reserved;
      logic debug_pin_enable;
      logic opt1_locked;
      logic watchdog_clock_select;
      logic opt2_locked;
      logic wakeup_timeout_flag;
      logic wakeup_clock_select;
      logic wakeup_irq_enable;
      logic [2:0] wakeup_period_select;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic pend;
      logic pend_write;
      logic [7:0] pend_addr;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      logic irq;
      logic wakeup_irq;
      logic stop_grant;
      logic illegal_stop;
   } sysopt_state_t;
   // state of the wakeup period counter
   typedef struct packed {
      logic [SO_WAKE_CNT_W-1:0] count;
      logic timeout;
   } sysopt_wake_state_t;
endpackage

// *** hw/sysopt_wakeup_timer.sv ***
// periodic wakeup period counter
`timescale 1ns/1ps
`default_nettype none
module sysopt_wakeup_timer
   import sysopt_pkg::*;
(
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, active low
   input wire logic tick, // one-cycle time base tick
   input wire logic ext_clock, // 1 selects the 32 kHz base
   input wire logic [2:0] period_select, // 000 stops the timer
   output logic timeout // one-cycle period end pulse
);
   sysopt_wake_state_t s_reg;
   sysopt_wake_state_t s_next;

   // last count of a period, ticks per period less one, for a select code and time base
   function automatic logic [SO_WAKE_CNT_W-1:0] wake_limit(input logic [2:0] sel, input logic ext);
      logic [31:0] ticks;
      ticks = (sel == 3'h1) ? SO_WAKE_1K_FIRST : (SO_WAKE_1K_BASE << (sel - 3'h2));
      if (ext) begin
         ticks = ticks * SO_WAKE_EXT_MULT;
      end
      wake_limit = SO_WAKE_CNT_W'(ticks - 32'd1);
   endfunction

   // count ticks, wrap and pulse at the selected period
   always_comb begin
      s_next = s_reg;
      s_next.timeout = 1'b0;
      if (period_select == 3'h0) begin
         s_next.count = '0;
      end else if (tick) begin
         if (s_reg.count >= wake_limit(period_select, ext_clock)) begin
            s_next.count = '0;
            s_next.timeout = 1'b1;
         end else begin
            s_next.count = s_reg.count + 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign timeout = s_reg.timeout;
endmodule
`default_nettype wire

// *** hw/sysopt_regs.sv ***
// system option control register bank with its ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module sysopt_regs
   import sysopt_pkg::*;
#(
   parameter logic [3:0] REVISION = 4'h1, // arbitrary value
   parameter logic [11:0] PART_NUMBER = 12'h5a3 // arbitrary value
) (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // system reset, async, active low
   input wire logic por_n, // power-on reset, async, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size, words only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire logic tick_1khz, // 1 kHz oscillator pin
   input wire logic tick_32khz, // 32 kHz clock pin
   input wire logic stop_exec, // cpu executes a stop, one cycle
   output logic stop_grant, // stop allowed, pulse
   output logic illegal_stop_reset, // stop refused, pulse
   output logic watchdog_enable, // watchdog on
   output logic watchdog_long_timeout, // long watchdog period
   output logic watchdog_clock_select, // watchdog time base
   output logic debug_pin_enable, // shared pin in debug use
   output logic reset_pin_enable, // shared pin is reset input
   output logic reset_pin_pullup_en, // pull-up on reset pin
   output logic wakeup_irq_req, // wakeup timer interrupt
   output logic irq // masked status interrupt
);
   sysopt_state_t s_reg;
   sysopt_state_t s_next;
   logic rstpin_reg;
   logic rstpin_next;
   logic wake_timeout;
   logic wake_tick;
   logic accept;
   logic do_write;
   logic do_read;
   logic opt1_wr;
   logic [7:0] rbyte;
   logic [7:0] wbyte;

   // periodic wakeup period counter
   sysopt_wakeup_timer sysopt_wakeup_timer_i (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(wake_tick),
      .ext_clock(s_reg.wakeup_clock_select),
      .period_select(s_reg.wakeup_period_select),
      .timeout(wake_timeout)
   );

   // bus phase qualifiers
   assign accept = hsel & hready & htrans[1];
   assign do_write = s_reg.pend & s_reg.pend_write;
   assign do_read = s_reg.pend & ~s_reg.pend_write;
   assign wbyte = hwdata[7:0];
   assign opt1_wr = do_write & (s_reg.pend_addr == SO_OFF_OPT1) & ~s_reg.opt1_locked;
   // rising edge of the chosen time base, taken after the second sync flop
   assign wake_tick = s_reg.wakeup_clock_select ? (s_reg.sync_32k[1] & ~s_reg.sync_32k[2])
                                                : (s_reg.sync_1k[1] & ~s_reg.sync_1k[2]);

   // read mux of the pending address
   always_comb begin
      rbyte = 8'h00;
      if (s_reg.pend_addr == SO_OFF_OPT1) begin
         rbyte[SO_OPT1_WDOG_EN_BIT] = s_reg.watchdog_enable;
         rbyte[SO_OPT1_WDOG_LONG_BIT] = s_reg.watchdog_long_timeout;
         rbyte[SO_OPT1_SLEEP_BIT] = s_reg.deep_sleep_permit;
         rbyte[SO_OPT1_RSVD_BIT] = s_reg.opt1_reserved;
         rbyte[SO_OPT1_DEBUG_BIT] = s_reg.debug_pin_enable;
         rbyte[SO_OPT1_RSTPIN_BIT] = rstpin_reg; // bits 3 and 2 stay zero
      end else if (s_reg.pend_addr == SO_OFF_OPT2) begin
         rbyte[SO_OPT2_WDOG_CLK_BIT] = s_reg.watchdog_clock_select;
      end else if (s_reg.pend_addr == SO_OFF_IDH) begin
         rbyte = {REVISION, PART_NUMBER[11:8]};
      end else if (s_reg.pend_addr == SO_OFF_IDL) begin
         rbyte = PART_NUMBER[7:0];
      end else if (s_reg.pend_addr == SO_OFF_WAKE) begin
         rbyte[SO_WAKE_FLAG_BIT] = s_reg.wakeup_timeout_flag; // ack and bit 3 read zero
         rbyte[SO_WAKE_CLK_BIT] = s_reg.wakeup_clock_select;
         rbyte[SO_WAKE_IE_BIT] = s_reg.wakeup_irq_enable;
         rbyte[SO_WAKE_SEL_LSB +: 3] = s_reg.wakeup_period_select;
      end else if (s_reg.pend_addr == SO_OFF_IRQ_STAT) begin
         rbyte[1:0] = s_reg.irq_status;
      end else if (s_reg.pend_addr == SO_OFF_IRQ_MASK) begin
         rbyte[1:0] = s_reg.irq_mask;
      end
   end

   // next state of the whole bank but the reset pin bit
   always_comb begin
      s_next = s_reg;
      // two-flop synchronisers plus a history flop
      s_next.sync_1k = {s_reg.sync_1k[1:0], tick_1khz};
      s_next.sync_32k = {s_reg.sync_32k[1:0], tick_32khz};
      // stop request steered by the sleep permit
      s_next.stop_grant = stop_exec & s_reg.deep_sleep_permit;
      s_next.illegal_stop = stop_exec & ~s_reg.deep_sleep_permit;
      s_next.resp = 1'b0;
      // one wait state: address captured, then data phase completes
      s_next.pend = accept;
      s_next.ready = ~accept;
      if (accept) begin
         s_next.pend_write = hwrite;
         s_next.pend_addr = haddr[7:0];
      end
      if (do_write) begin
         if (opt1_wr) begin
            s_next.watchdog_enable = wbyte[SO_OPT1_WDOG_EN_BIT];
            s_next.watchdog_long_timeout = wbyte[SO_OPT1_WDOG_LONG_BIT];
            s_next.deep_sleep_permit = wbyte[SO_OPT1_SLEEP_BIT];
            s_next.opt1_reserved = wbyte[SO_OPT1_RSVD_BIT];
            s_next.debug_pin_enable = wbyte[SO_OPT1_DEBUG_BIT];
            s_next.opt1_locked = 1'b1;
         end else if (s_reg.pend_addr == SO_OFF_OPT2 && !s_reg.opt2_locked) begin
            s_next.watchdog_clock_select = wbyte[SO_OPT2_WDOG_CLK_BIT];
            s_next.opt2_locked = 1'b1;
         end else if (s_reg.pend_addr == SO_OFF_WAKE) begin
            s_next.wakeup_clock_select = wbyte[SO_WAKE_CLK_BIT];
            s_next.wakeup_irq_enable = wbyte[SO_WAKE_IE_BIT];
            s_next.wakeup_period_select = wbyte[SO_WAKE_SEL_LSB +: 3];
            if (wbyte[SO_WAKE_ACK_BIT]) begin
               s_next.wakeup_timeout_flag = 1'b0;
            end
         end else if (s_reg.pend_addr == SO_OFF_IRQ_MASK) begin
            s_next.irq_mask = wbyte[1:0];
         end
      end
      if (do_read) begin
         s_next.rdata = {24'h000000, rbyte};
         if (s_reg.pend_addr == SO_OFF_IRQ_STAT) begin
            s_next.irq_status = 2'h0;
         end
      end
      // events win over clears in the same cycle
      if (wake_timeout) begin
         s_next.wakeup_timeout_flag = 1'b1;
         s_next.irq_status[SO_IRQ_WAKE_BIT] = 1'b1;
      end
      if (s_next.illegal_stop) begin
         s_next.irq_status[SO_IRQ_STOP_BIT] = 1'b1;
      end
      s_next.irq = |(s_next.irq_status & s_next.irq_mask);
      s_next.wakeup_irq = s_next.wakeup_timeout_flag & s_next.wakeup_irq_enable;
   end

   // bank register, any system reset restores it and clears both locks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
         s_reg.watchdog_enable <= SO_RST_WDOG_EN;
         s_reg.watchdog_long_timeout <= SO_RST_WDOG_LONG;
         s_reg.deep_sleep_permit <= SO_RST_SLEEP;
         s_reg.opt1_reserved <= SO_RST_RSVD;
         s_reg.debug_pin_enable <= SO_RST_DEBUG;
         s_reg.watchdog_clock_select <= SO_RST_WDOG_CLK;
         s_reg.wakeup_clock_select <= SO_RST_WAKE[SO_WAKE_CLK_BIT];
         s_reg.wakeup_irq_enable <= SO_RST_WAKE[SO_WAKE_IE_BIT];
         s_reg.ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // reset pin enable survives every reset but power-on
   always_comb begin
      rstpin_next = opt1_wr ? wbyte[SO_OPT1_RSTPIN_BIT] : rstpin_reg;
   end

   // power-on domain flop
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         rstpin_reg <= SO_RST_RSTPIN;
      end else begin
         rstpin_reg <= rstpin_next;
      end
   end

   // outputs straight from flops
   assign hrdata = s_reg.rdata;
   assign hreadyout = s_reg.ready;
   assign hresp = s_reg.resp;
   assign stop_grant = s_reg.stop_grant;
   assign illegal_stop_reset = s_reg.illegal_stop;
   assign watchdog_enable = s_reg.watchdog_enable;
   assign watchdog_long_timeout = s_reg.watchdog_long_timeout;
   assign watchdog_clock_select = s_reg.watchdog_clock_select;
   assign debug_pin_enable = s_reg.debug_pin_enable;
   assign reset_pin_enable = rstpin_reg;
   assign reset_pin_pullup_en = rstpin_reg;
   assign wakeup_irq_req = s_reg.wakeup_irq;
   assign irq = s_reg.irq;

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_opt1_write_once: assert property (
      s_reg.opt1_locked && do_write |=> $stable({s_reg.watchdog_enable, s_reg.watchdog_long_timeout,
                                               s_reg.deep_sleep_permit, s_reg.debug_pin_enable,
                                               s_reg.opt1_reserved, rstpin_reg}))
      else $error("locked options register changed");
   chk_opt1_reset_vals: assert property (
      !s_reg.opt1_locked |-> watchdog_enable && watchdog_long_timeout && debug_pin_enable
                             && !s_reg.deep_sleep_permit)
      else $error("options register left reset values before any write");
   chk_stop_refused: assert property (
      stop_exec && !s_reg.deep_sleep_permit |=> illegal_stop_reset && !stop_grant)
      else $error("refused stop did not give illegal reset");
   chk_opt2_write_once: assert property (
      s_reg.opt2_locked |=> $stable(watchdog_clock_select))
      else $error("locked watchdog clock select changed");
   chk_ident_high_read: assert property (
      do_read && s_reg.pend_addr == SO_OFF_IDH |=> hreadyout && hrdata == {24'h000000, REVISION,
                                                                          PART_NUMBER[11:8]})
      else $error("ident high read wrong");
   chk_wake_zero_bits: assert property (
      do_read && s_reg.pend_addr == SO_OFF_WAKE |=> hrdata[SO_WAKE_ACK_BIT] == 1'b0 && hrdata[3] == 1'b0)
      else $error("wakeup ack or bit 3 read nonzero");
   chk_opt1_zero_bits: assert property (
      do_read && s_reg.pend_addr == SO_OFF_OPT1 |=> hrdata[3:2] == 2'h0)
      else $error("options bits 3 and 2 read nonzero");
   chk_ack_clears_flag: assert property (
      do_write && s_reg.pend_addr == SO_OFF_WAKE && wbyte[SO_WAKE_ACK_BIT] && !wake_timeout
      |=> !s_reg.wakeup_timeout_flag)
      else $error("ack did not clear timeout flag");
   chk_wake_irq_level: assert property (
      wakeup_irq_req == (s_reg.wakeup_timeout_flag && s_reg.wakeup_irq_enable))
      else $error("wakeup request disagrees with flag and enable");
   chk_wait_state: assert property (
      accept |=> !hreadyout ##1 hreadyout)
      else $error("data phase not one wait state");

   cov_opt1_written: cover property (opt1_wr);
   cov_wake_timeout: cover property (wake_timeout ##[1:10] s_reg.wakeup_timeout_flag);
   cov_stop_refused: cover property (illegal_stop_reset);
   cov_irq_raised: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** verification/sysopt_regs_test.sv ***
// self-checking testbench for the system option control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("Error at time %0t: got 0x%h expected 0x%h", $time, (got), (exp)); \
      end \
   end
module sysopt_regs_test;
   import sysopt_pkg::*;
   localparam logic [3:0] REV_V = 4'h6; // arbitrary value
   localparam logic [11:0] PN_V = 12'h2b7; // arbitrary value
   logic hclk, hresetn, por_n, hsel, hwrite, hready_o, hresp, stop_exec, stop_grant, illegal_stop_reset;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic tick_1khz, tick_32khz, irq, wakeup_irq_req;
   logic watchdog_enable, watchdog_long_timeout, watchdog_clock_select;
   logic debug_pin_enable, reset_pin_enable, reset_pin_pullup_en;
   logic [4:0] opt_pins;
   int fail_count = 0;
   int tests_run = 0;
   int per_1k [1:7] = '{8, 32, 64, 128, 256, 512, 1024};

   sysopt_regs #(.REVISION(REV_V), .PART_NUMBER(PN_V)) sysopt_regs_i (
      .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_o), .hrdata(hrdata),
      .hreadyout(hready_o), .hresp(hresp), .tick_1khz(tick_1khz), .tick_32khz(tick_32khz),
      .stop_exec(stop_exec), .stop_grant(stop_grant), .illegal_stop_reset(illegal_stop_reset),
      .watchdog_enable(watchdog_enable), .watchdog_long_timeout(watchdog_long_timeout),
      .watchdog_clock_select(watchdog_clock_select), .debug_pin_enable(debug_pin_enable),
      .reset_pin_enable(reset_pin_enable), .reset_pin_pullup_en(reset_pin_pullup_en),
      .wakeup_irq_req(wakeup_irq_req), .irq(irq)
   );

   // option pin levels gathered for short compares
   assign opt_pins = {watchdog_enable, watchdog_long_timeout, debug_pin_enable, reset_pin_enable, reset_pin_pullup_en};

   // 250 MHz bus clock
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // counts and verdict, the single end of the run
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // one ahb-lite single word transfer, entered just after a rising edge
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready_o !== 1'b1 && n < 50);
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         n++;
      end while (hready_o !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50) begin
         fail_count++;
         print_verdict();
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, {24'h0, d}, r);
   endtask

   task chk_rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h0, r);
      `CHECK_EQ(r, exp)
   endtask

   // let registered levels follow a register change
   task settle;
      repeat (2) @(posedge hclk);
   endtask

   // reset pulse, system only or with power-on
   task do_reset(input logic por);
      hresetn <= 1'b0;
      por_n <= ~por;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge hclk);
   endtask

   // n rising edges on one time base pin, eight bus cycles apart
   task pulses(input int n, input logic ext);
      for (int i = 0; i < n; i++) begin
         if (ext) begin
            tick_32khz <= 1'b1;
         end else begin
            tick_1khz <= 1'b1;
         end
         repeat (4) @(posedge hclk);
         tick_32khz <= 1'b0;
         tick_1khz <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask

   // stop request and the granted or refused pulse one cycle later
   task stop_try(input logic exp_grant);
      stop_exec <= 1'b1;
      @(posedge hclk);
      stop_exec <= 1'b0;
      @(posedge hclk);
      `CHECK_EQ(stop_grant, exp_grant)
      `CHECK_EQ(illegal_stop_reset, ~exp_grant)
      @(posedge hclk);
      `CHECK_EQ(stop_grant | illegal_stop_reset, 1'b0)
   endtask

   // main sequence
   initial begin
      hresetn = 1'b0;
      por_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      tick_1khz = 1'b0;
      tick_32khz = 1'b0;
      stop_exec = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge hclk);
      // reset values, identification and unmapped space
      `CHECK_EQ(hresp, 1'b0)
      chk_rd(SO_OFF_OPT1, 32'h0000_00d2);
      `CHECK_EQ(opt_pins[4:1], 4'b1110)
      chk_rd(SO_OFF_OPT2, 32'h0);
      chk_rd(SO_OFF_WAKE, 32'h0);
      wr(SO_OFF_IDH, 8'h00);
      chk_rd(SO_OFF_IDH, {24'h0, REV_V, PN_V[11:8]});
      wr(SO_OFF_IDL, 8'hff);
      chk_rd(SO_OFF_IDL, {24'h0, PN_V[7:0]});
      wr(8'h1c, 8'hff);
      chk_rd(8'h1c, 32'h0);
      stop_try(1'b0);
      // first write taken, later ones dropped
      wr(SO_OFF_OPT1, 8'h2d);
      chk_rd(SO_OFF_OPT1, 32'h21);
      `CHECK_EQ(opt_pins, 5'b00011)
      wr(SO_OFF_OPT1, 8'hff);
      chk_rd(SO_OFF_OPT1, 32'h21);
      stop_try(1'b1);
      wr(SO_OFF_OPT2, 8'h80);
      chk_rd(SO_OFF_OPT2, 32'h80);
      `CHECK_EQ(watchdog_clock_select, 1'b1)
      wr(SO_OFF_OPT2, 8'h00);
      chk_rd(SO_OFF_OPT2, 32'h80);
      // system reset keeps the reset pin bit and frees both locks
      do_reset(1'b0);
      chk_rd(SO_OFF_OPT1, 32'hd3);
      chk_rd(SO_OFF_OPT2, 32'h0);
      wr(SO_OFF_OPT2, 8'h80);
      chk_rd(SO_OFF_OPT2, 32'h80);
      wr(SO_OFF_OPT1, 8'h10);
      chk_rd(SO_OFF_OPT1, 32'h10);
      `CHECK_EQ({opt_pins[4:3], opt_pins[1]}, 3'b000)
      // refused stop raises a maskable status bit
      chk_rd(SO_OFF_IRQ_STAT, 32'h0);
      stop_try(1'b0);
      `CHECK_EQ(irq, 1'b0)
      wr(SO_OFF_IRQ_MASK, 8'h02);
      settle();
      `CHECK_EQ(irq, 1'b1)
      chk_rd(SO_OFF_IRQ_MASK, 32'h02);
      chk_rd(SO_OFF_IRQ_STAT, 32'h02);
      settle();
      `CHECK_EQ(irq, 1'b0)
      wr(SO_OFF_IRQ_MASK, 8'h00);
      // every period select on the 1 kHz base
      for (int s = 1; s <= 7; s++) begin
         wr(SO_OFF_WAKE, 8'h00);
         wr(SO_OFF_WAKE, 8'h50 | 8'(s));
         pulses(per_1k[s] - 1, 1'b0);
         `CHECK_EQ(wakeup_irq_req, 1'b0)
         pulses(1, 1'b0);
         `CHECK_EQ(wakeup_irq_req, 1'b1)
         chk_rd(SO_OFF_WAKE, {24'h0, 8'h90 | 8'(s)});
      end
      // ack written 0 keeps the flag, enable gates the request
      wr(SO_OFF_WAKE, 8'h17);
      chk_rd(SO_OFF_WAKE, 32'h97);
      wr(SO_OFF_WAKE, 8'h07);
      settle();
      `CHECK_EQ(wakeup_irq_req, 1'b0)
      wr(SO_OFF_IRQ_MASK, 8'h01);
      settle();
      `CHECK_EQ(irq, 1'b1)
      chk_rd(SO_OFF_IRQ_STAT, 32'h01);
      settle();
      `CHECK_EQ(irq, 1'b0)
      wr(SO_OFF_WAKE, 8'h47);
      chk_rd(SO_OFF_WAKE, 32'h07);
      // 32 kHz base, 1 kHz edges ignored meanwhile
      wr(SO_OFF_WAKE, 8'h00);
      wr(SO_OFF_WAKE, 8'h31);
      pulses(255, 1'b1);
      pulses(20, 1'b0);
      `CHECK_EQ(wakeup_irq_req, 1'b0)
      pulses(1, 1'b1);
      `CHECK_EQ(wakeup_irq_req, 1'b1)
      chk_rd(SO_OFF_WAKE, 32'hb1);
      // select 000 stops the timer
      wr(SO_OFF_WAKE, 8'h70);
      pulses(300, 1'b1);
      chk_rd(SO_OFF_WAKE, 32'h30);
      `CHECK_EQ(wakeup_irq_req, 1'b0)
      // power-on reset clears the reset pin bit
      do_reset(1'b0);
      wr(SO_OFF_OPT1, 8'h01);
      chk_rd(SO_OFF_OPT1, 32'h01);
      do_reset(1'b1);
      chk_rd(SO_OFF_OPT1, 32'hd2);
      `CHECK_EQ(reset_pin_pullup_en, 1'b0)
      print_verdict();
   end
endmodule
`undef CHECK_EQ
`default_nettype wire
